// [rtl/psq_regs.svh]
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH
`define PSQ_PC_W          10
`define PSQ_RESET_VEC     10'h000
`define PSQ_SWI_VEC       10'h001
`define PSQ_HWI_VEC       10'h008
`define PSQ_STACK_DEPTH   8
`define PSQ_SP_W          3
`define PSQ_CLK_PER_CYC   3'h4
`define PSQ_CALL_MASK     10'h0FF
`define PSQ_MJMP_MASK     10'h1FF
`define PSQ_IRQ_TMR0      0
`define PSQ_IRQ_TMR1      1
`define PSQ_IRQ_WDOG      2
`define PSQ_IRQ_PCHG      3
`define PSQ_IRQ_EXT       4
`define PSQ_HALT_WAKE_MASK 5'h1C
`endif

// [rtl/psq_pkg.sv]
package psq_pkg;
  typedef enum logic [3:0] {
    PSQ_OP_NONE    = 4'b0000,
    PSQ_OP_SEQ     = 4'b0001,
    PSQ_OP_SKIP    = 4'b0010,
    PSQ_OP_SCALL   = 4'b0011,
    PSQ_OP_TJUMP   = 4'b0100,
    PSQ_OP_TCALL   = 4'b0101,
    PSQ_OP_MJUMP   = 4'b0110,
    PSQ_OP_LONG_SUBROUTINE_JUMP   = 4'b0111,
    PSQ_OP_LJUMP   = 4'b1000,
    PSQ_OP_RET     = 4'b1001,
    PSQ_OP_RETLIT  = 4'b1010,
    PSQ_OP_RETI    = 4'b1011,
    PSQ_OP_SWI     = 4'b1100,
    PSQ_OP_PCLWR   = 4'b1101
  } psq_op_e;
  typedef enum logic [1:0] {
    PSQ_PM_NORMAL  = 2'b00,
    PSQ_PM_SLOW    = 2'b01,
    PSQ_PM_STANDBY = 2'b10,
    PSQ_PM_HALT    = 2'b11
  } psq_pmode_e;
  typedef logic [9:0] psq_addr_t;
endpackage

// [rtl/psq_stack_if.sv]
`timescale 1ns/100ps
interface psq_stack_if;
  logic       push;
  logic       pop;
  logic [9:0] push_addr;
  logic [9:0] top_addr;
  modport owner (output push, output pop, output push_addr, input top_addr);
  modport store (input push, input pop, input push_addr, output top_addr);
endinterface

// [rtl/psq_ret_stack.sv]
`timescale 1ns/100ps
`include "psq_regs.svh"
module psq_ret_stack (
  input  wire logic  i_ref_clk,
  input  wire logic  i_sys_rst,
  psq_stack_if.store s_stk
);
  import psq_pkg::*;
  typedef struct packed {
    logic [`PSQ_STACK_DEPTH-1:0][`PSQ_PC_W-1:0] mem;
    logic [`PSQ_SP_W-1:0]                       sp;
    logic [`PSQ_PC_W-1:0]                       top;
  } psq_stk_s;
  psq_stk_s st_q;
  psq_stk_s st_d;
  logic [`PSQ_SP_W-1:0] sp_dec;
  assign sp_dec         = st_q.sp - 3'h1;
  assign s_stk.top_addr = st_q.top;
  // ==========================================
  // circular store: overflow overwrites oldest, no flag
  always_comb begin
    st_d = st_q;
    if (s_stk.push) begin
      st_d.mem[st_q.sp] = s_stk.push_addr;
      st_d.sp           = st_q.sp + 3'h1;
      st_d.top          = s_stk.push_addr;
    end else if (s_stk.pop) begin
      st_d.sp  = sp_dec;
      st_d.top = st_q.mem[sp_dec - 3'h1];
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // psq_ret_stack

// [rtl/psq_sequencer.sv]
`timescale 1ns/100ps
`include "psq_regs.svh"
// How it works
// - program counter is ten bits, covering the whole 1K-word program memory.
// - reset loads counter with 0x000 and fetching starts there.
// - software interrupt jumps to address 0x001.
// - every hardware interrupt jumps to shared address 0x008.
// - short call and table jump/call reach 256 locations.
// - medium jump reaches 512 locations.
// - long call and long jump reach the whole program memory.
// - calls and software interrupts push the next word address onto the stack; hardware interrupts push the interrupted address.
// - all three return kinds pop the top entry into the counter.
// - return stack is hardware, eight entries deep.
// - instructions take one cycle; branches and taken skips take two.
// - one instruction cycle lasts four system clocks.
// - pin 0 is external interrupt only when select and enable both set.
// - five hardware sources: timer0, timer1, watchdog, pin change, external.
// - in standby any of the five sources wakes the device.
// - in halt only watchdog, pin change and external wake the device.
// - low on pin 3, when set as reset input, resets the device.
// - counter advances by one per non-bubble cycle in normal and slow mode unless an instruction or hardware interrupt writes it.
// - on a low-byte write, counter top two bits load only from the high-byte buffer.
module psq_sequencer (
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire psq_pkg::psq_op_e  i_op,
  input  wire logic [9:0]        i_target,
  input  wire logic              i_skip_taken,
  input  wire logic [7:0]        i_pc_low_byte,
  input  wire logic [1:0]        i_pc_high_buffer,
  input  wire logic [4:0]        i_irq_flags,
  input  wire logic              i_gie,
  input  wire psq_pkg::psq_pmode_e i_pmode,
  input  wire logic              i_port_pin_0,
  input  wire logic              i_ext_irq_select,
  input  wire logic              i_ext_irq_enable,
  input  wire logic              i_port_pin_3,
  input  wire logic              i_pin3_is_reset,
  output logic [9:0]             o_pc,
  output logic                   o_fetch,
  output logic                   o_cycle_end,
  output logic                   o_irq_taken,
  output logic                   o_wake,
  output logic                   o_core_rst,
  output logic [4:0]             o_irq_src
);
  import psq_pkg::*;

  typedef struct packed {
    logic [9:0] pc;
    logic [1:0] phase;
    logic       bubble;
    logic       ext_prev;
    logic       ext_evt;
    logic       fetch;
    logic       cyc_end;
    logic       irq_tk;
    logic       wake;
    logic [4:0] src;
  } psq_seq_s;

  psq_seq_s    sq_q;
  psq_seq_s    sq_d;
  psq_stack_if stk ();
  logic        rst_all;
  logic        ext_pin_live;
  logic [4:0]  pend;
  logic [4:0]  wake_src;
  logic        last_clk;
  logic [9:0]  pc_inc;

  // ==========================================
  // reset and interrupt qualification
  assign rst_all      = i_sys_rst | (i_pin3_is_reset & ~i_port_pin_3);
  assign ext_pin_live = i_ext_irq_select & i_ext_irq_enable;
  // external event is a falling edge only while pin 0 owns the interrupt role
  always_comb begin
    pend                = i_irq_flags;
    pend[`PSQ_IRQ_EXT]  = i_irq_flags[`PSQ_IRQ_EXT] | sq_q.ext_evt;
  end
  // halt stops the timers' clock, so only three sources may wake it
  always_comb begin
    wake_src = '0;
    if (i_pmode == PSQ_PM_STANDBY) begin
      wake_src = pend;
    end else if (i_pmode == PSQ_PM_HALT) begin
      wake_src = pend & `PSQ_HALT_WAKE_MASK;
    end
  end

  psq_ret_stack u_stack (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (rst_all),
    .s_stk     (stk)
  );

  assign last_clk = (sq_q.phase == 2'(`PSQ_CLK_PER_CYC - 3'h1));
  assign pc_inc   = sq_q.pc + 10'h001;

  // ==========================================
  // next program counter
  always_comb begin
    sq_d          = sq_q;
    stk.push      = 1'b0;
    stk.pop       = 1'b0;
    stk.push_addr = pc_inc;
    sq_d.phase    = sq_q.phase + 2'h1;
    sq_d.fetch    = 1'b0;
    sq_d.cyc_end  = last_clk;
    sq_d.irq_tk   = 1'b0;
    sq_d.wake     = |wake_src;
    sq_d.src      = pend;
    sq_d.ext_prev = i_port_pin_0;
    if (ext_pin_live && sq_q.ext_prev && !i_port_pin_0) begin
      sq_d.ext_evt = 1'b1;
    end else if (last_clk) begin
      sq_d.ext_evt = 1'b0;
    end
    if (last_clk) begin
      sq_d.fetch = 1'b1;
      if (sq_q.bubble) begin
        sq_d.bubble = 1'b0;
      end else if (i_gie && (|pend) && (i_pmode == PSQ_PM_NORMAL || i_pmode == PSQ_PM_SLOW)) begin
        stk.push_addr = sq_q.pc;
        stk.push      = 1'b1;
        sq_d.pc       = `PSQ_HWI_VEC;
        sq_d.irq_tk   = 1'b1;
        sq_d.bubble   = 1'b1;
      end else if (i_pmode == PSQ_PM_STANDBY || i_pmode == PSQ_PM_HALT) begin
        sq_d.fetch = 1'b0; // pc frozen while asleep
      end else begin
        sq_d.pc = pc_inc;
        case (i_op)
          PSQ_OP_SKIP: begin
            if (i_skip_taken) begin
              sq_d.pc     = sq_q.pc + 10'h002;
              sq_d.bubble = 1'b1;
            end
          end
          PSQ_OP_SCALL, PSQ_OP_TCALL: begin
            stk.push    = 1'b1;
            sq_d.pc     = (sq_q.pc & ~`PSQ_CALL_MASK) | (i_target & `PSQ_CALL_MASK);
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_TJUMP: begin
            sq_d.pc     = (sq_q.pc & ~`PSQ_CALL_MASK) | (i_target & `PSQ_CALL_MASK);
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_MJUMP: begin
            sq_d.pc     = (sq_q.pc & ~`PSQ_MJMP_MASK) | (i_target & `PSQ_MJMP_MASK);
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_LONG_SUBROUTINE_JUMP: begin
            stk.push    = 1'b1;
            sq_d.pc     = i_target;
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_LJUMP: begin
            sq_d.pc     = i_target;
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_RET, PSQ_OP_RETLIT, PSQ_OP_RETI: begin
            stk.pop     = 1'b1;
            sq_d.pc     = stk.top_addr;
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_SWI: begin
            stk.push    = 1'b1;
            sq_d.pc     = `PSQ_SWI_VEC;
            sq_d.bubble = 1'b1;
          end
          PSQ_OP_PCLWR: begin
            sq_d.pc     = {i_pc_high_buffer, i_pc_low_byte};
            sq_d.bubble = 1'b1;
          end
          default: begin
            sq_d.pc = pc_inc;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      sq_q    <= '0;
      sq_q.pc <= `PSQ_RESET_VEC;
    end else begin
      sq_q <= sq_d;
    end
  end

  assign o_pc        = sq_q.pc;
  assign o_fetch     = sq_q.fetch;
  assign o_cycle_end = sq_q.cyc_end;
  assign o_irq_taken = sq_q.irq_tk;
  assign o_wake      = sq_q.wake;
  assign o_irq_src   = sq_q.src;
  assign o_core_rst  = rst_all;
endmodule // psq_sequencer

// [testbench/psq_seq_monitor.sv]
`timescale 1ns/100ps
module psq_seq_monitor
  import psq_pkg::*;
(
  input wire logic                i_ref_clk,
  input wire logic                i_sys_rst,
  input wire logic [4:0]          i_irq_flags,
  input wire psq_pkg::psq_pmode_e i_pmode,
  input wire logic                i_port_pin_3,
  input wire logic                i_pin3_is_reset,
  input wire logic                i_ext_irq_select,
  input wire logic                i_ext_irq_enable,
  input wire logic [9:0]          o_pc,
  input wire logic                o_fetch,
  input wire logic                o_cycle_end,
  input wire logic                o_irq_taken,
  input wire logic                o_wake,
  input wire logic                o_core_rst,
  input wire logic [4:0]          o_irq_src
);
  // ==========
  // sequences
  default clocking @(posedge i_ref_clk); endclocking
  // pin 3 reset restarts the cycle counter as well, so it must mute checks too
  default disable iff (o_core_rst);
  sequence s_next_cycle;
    !o_cycle_end [*3] ##1 o_cycle_end;
  endsequence
  sequence s_halt_quiet;
    $past(i_pmode) == PSQ_PM_HALT && o_irq_src[4:2] == 3'h0;
  endsequence
  // ==========
  // properties
  a_cycle_four: assert property (o_cycle_end |=> s_next_cycle)
    else $error("cycle length wrong");
  a_pc_fetch: assert property (!(i_pin3_is_reset && !i_port_pin_3) && !$stable(o_pc) |-> o_fetch)
    else $error("pc moved without fetch");
  a_reset_pc: assert property ($fell(i_sys_rst) |-> o_pc == 10'h000)
    else $error("pc not zero after reset");
  a_irq_vector: assert property (o_irq_taken |-> o_pc == 10'h008)
    else $error("irq entry not at shared vector");
  a_irq_bubble: assert property (o_irq_taken |=> $stable(o_pc) [*7])
    else $error("no bubble after irq entry");
  a_sleep_no_irq: assert property (i_pmode[1] |=> !o_irq_taken)
    else $error("irq entered while asleep");
  a_halt_timer: assert property (s_halt_quiet |-> !o_wake)
    else $error("timer woke halt");
  a_standby_wake: assert property ((i_pmode == PSQ_PM_STANDBY && i_irq_flags != 5'h00) [*3] |-> o_wake)
    else $error("standby not woken");
endmodule // psq_seq_monitor
bind psq_sequencer psq_seq_monitor i_mon (.i_ref_clk, .i_sys_rst, .i_irq_flags, .i_pmode, .i_port_pin_3,
  .i_pin3_is_reset, .i_ext_irq_select, .i_ext_irq_enable, .o_pc, .o_fetch, .o_cycle_end, .o_irq_taken, .o_wake,
  .o_core_rst, .o_irq_src);

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  import psq_pkg::*;
  logic       i_ref_clk = 0, i_sys_rst = 1, i_skip_taken = 0, i_gie = 0, i_port_pin_0 = 1, i_port_pin_3 = 1;
  logic       i_ext_irq_select = 0, i_ext_irq_enable = 0, i_pin3_is_reset = 0;
  psq_op_e    i_op = PSQ_OP_NONE;
  psq_pmode_e i_pmode = PSQ_PM_NORMAL;
  logic [9:0] i_target = 0, o_pc, ex, stk [8];
  logic [7:0] i_pc_low_byte = 0;
  logic [1:0] i_pc_high_buffer = 0;
  logic [4:0] i_irq_flags = 0, o_irq_src;
  logic [2:0] sp = 0;
  logic       o_fetch, o_cycle_end, o_irq_taken, o_wake, o_core_rst;
  int         n_fail = 0, checks = 0;
  psq_op_e    cl [4] = '{PSQ_OP_SCALL, PSQ_OP_TCALL, PSQ_OP_SWI, PSQ_OP_LONG_SUBROUTINE_JUMP};
  psq_op_e    rt [3] = '{PSQ_OP_RET, PSQ_OP_RETLIT, PSQ_OP_RETI};
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
  always #2.5 i_ref_clk = ~i_ref_clk;
  psq_sequencer i_psq_sequencer (.i_ref_clk, .i_sys_rst, .i_op, .i_target, .i_skip_taken, .i_pc_low_byte,
    .i_pc_high_buffer, .i_irq_flags, .i_gie, .i_pmode, .i_port_pin_0, .i_ext_irq_select, .i_ext_irq_enable,
    .i_port_pin_3, .i_pin3_is_reset, .o_pc, .o_fetch, .o_cycle_end, .o_irq_taken, .o_wake, .o_core_rst, .o_irq_src);
  // ==========
  // model
  function automatic logic [9:0] rnd();
    logic [9:0] t;
    t = 10'($urandom);
    if (t[9:1] == 9'h007 || t[9:1] == 9'h1FF) t = t ^ 10'h010;
    return t;
  endfunction
  task automatic push(logic [9:0] v);
    stk[sp] = v;
    sp = sp + 3'h1;
  endtask
  task automatic step(psq_op_e op, logic [9:0] t);
    i_op <= op;
    i_target <= t;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic go(psq_op_e op, logic [9:0] t);
    logic bub;
    bub = 1;
    case (op)
      PSQ_OP_SEQ, PSQ_OP_SKIP: begin ex = ex + 10'h1; bub = 0; end
      PSQ_OP_SCALL, PSQ_OP_TCALL: begin push(ex + 10'h1); ex[7:0] = t[7:0]; end
      PSQ_OP_TJUMP: ex[7:0] = t[7:0];
      PSQ_OP_MJUMP: ex[8:0] = t[8:0];
      PSQ_OP_LONG_SUBROUTINE_JUMP: begin push(ex + 10'h1); ex = t; end
      PSQ_OP_LJUMP: ex = t;
      PSQ_OP_SWI: begin push(ex + 10'h1); ex = 10'h001; end
      default: begin sp = sp - 3'h1; ex = stk[sp]; end
    endcase
    step(op, t);
    `CHK("pc", ex, o_pc)
    if (bub) begin step(PSQ_OP_SEQ, 10'h0); `CHK("bubble pc", ex, o_pc) end
  endtask
  // hardware entry pushes the interrupted address
  task automatic hw(logic [4:0] f);
    i_irq_flags <= f;
    step(PSQ_OP_SEQ, 10'h0);
    push(ex);
    ex = 10'h008;
    `CHK("irq pc", ex, o_pc)
    i_irq_flags <= 5'h00;
    step(PSQ_OP_SEQ, 10'h0);
    go(PSQ_OP_RETI, 10'h0);
  endtask
  task automatic slp(psq_pmode_e m, logic [4:0] f, logic w);
    i_pmode <= m;
    i_irq_flags <= f;
    step(PSQ_OP_SEQ, 10'h0);
    `CHK("wake", w, o_wake)
    `CHK("irq src", f, o_irq_src)
    `CHK("sleep pc", ex, o_pc)
  endtask
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    void'($urandom(74433));
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 0;
    ex = 0;
    `CHK("reset pc", 10'h000, o_pc)
    go(PSQ_OP_SEQ, 10'h0);
    go(PSQ_OP_SKIP, 10'h0);
    repeat (9) go(PSQ_OP_LONG_SUBROUTINE_JUMP, rnd());
    repeat (8) go(rt[$urandom_range(2)], 10'h0);
    repeat (3) begin
      for (int k = 0; k < 4; k++) begin go(PSQ_OP_LJUMP, rnd()); go(cl[k], rnd()); end
      go(PSQ_OP_TJUMP, rnd());
      go(PSQ_OP_MJUMP, rnd());
      for (int k = 0; k < 4; k++) go(rt[k % 3], 10'h0);
    end
    i_gie <= 1;
    for (int b = 0; b < 5; b++) hw(5'h01 << b);
    i_ext_irq_select <= 1;
    i_port_pin_0 <= 0;
    go(PSQ_OP_SEQ, 10'h0);
    i_ext_irq_enable <= 1;
    i_port_pin_0 <= 1;
    go(PSQ_OP_SEQ, 10'h0);
    i_port_pin_0 <= 0;
    hw(5'h00);
    i_gie <= 0;
    slp(PSQ_PM_HALT, 5'h03, 1'b0);
    slp(PSQ_PM_HALT, 5'h08, 1'b1);
    slp(PSQ_PM_STANDBY, 5'h02, 1'b1);
    i_pmode <= PSQ_PM_NORMAL;
    i_irq_flags <= 5'h00;
    go(PSQ_OP_SEQ, 10'h0);
    i_pc_low_byte <= 8'h5A;
    i_pc_high_buffer <= 2'h2;
    step(PSQ_OP_PCLWR, 10'h0);
    `CHK("pc write", 10'h25A, o_pc)
    i_pin3_is_reset <= 1;
    i_port_pin_3 <= 0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK("core rst", 1'b1, o_core_rst)
    `CHK("pin3 pc", 10'h000, o_pc)
    i_port_pin_3 <= 1;
    ex = 0;
    go(PSQ_OP_SEQ, 10'h0);
    finish_test();
  end
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule // tb
